// ===== rtl/dac_link_pkg.sv
package dac_link_pkg;
  // command word layout
  localparam int WORD_W = 16;
  localparam int LEVEL_W = 10;
  localparam int CODE_MSB = 15;
  localparam int CODE_LSB = 12;
  localparam int LEVEL_MSB = 11;
  localparam int LEVEL_LSB = 2;
  localparam int SEL_MSB = 4;
  localparam int SEL_LSB = 2;
  localparam int TRAIL_MSB = 1;
  localparam int TRAIL_LSB = 0;
  localparam logic [4:0] LAST_BIT = 5'h0f;
  localparam logic [4:0] BITS_PER_WORD = 5'h10;
  // control codes
  localparam logic [3:0] CODE_LOAD_A = 4'h0;
  localparam logic [3:0] CODE_LOAD_B = 4'h1;
  localparam logic [3:0] CODE_STAGE_A = 4'h4;
  localparam logic [3:0] CODE_STAGE_B = 4'h5;
  localparam logic [3:0] CODE_XFER_A = 4'h8;
  localparam logic [3:0] CODE_XFER_B = 4'h9;
  localparam logic [3:0] CODE_LOAD_AB = 4'hc;
  localparam logic [3:0] CODE_STAGE_AB = 4'hd;
  localparam logic [3:0] CODE_XFER_AB = 4'he;
  localparam logic [3:0] CODE_POWER = 4'hf;
  // channel select values of a power command
  localparam logic [2:0] SEL_A = 3'h0;
  localparam logic [2:0] SEL_B = 3'h1;
  localparam logic [2:0] SEL_AB = 3'h4;
  // power states, in trailing-bit order
  typedef enum logic [1:0] {PWR_WAKE, PWR_FLOAT, PWR_1K, PWR_100K} power_t;
  // values after reset
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 10'h000;
  localparam power_t POWER_RESET = PWR_100K;
  // fsm states
  typedef enum logic [1:0] {DEV_IDLE, DEV_SHIFT, DEV_DONE} dev_state_t;
  typedef enum logic {HOST_IDLE, HOST_SHIFT} host_state_t;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CS_GAP_NS = 80;
  localparam int WAKE_US = 8;
  localparam int CS_GAP_CYCLES = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES = (WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYCLES = 13;
  // controller register map (byte addresses)
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_COMMAND = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam int ST_PENDING = 0;
  localparam int ST_FRAME = 1;
  localparam int ST_WAKE_WAIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/dac_serial_if.sv
`timescale 1ns/1ps
// three-wire command link; the host drives all wires
interface dac_serial_if;
  logic frame_n; // frame select, active low
  logic sclk;    // serial clock, sampled on falling edges
  logic sdata;   // serial data, msb first
  modport device (input frame_n, input sclk, input sdata);
  modport host (output frame_n, output sclk, output sdata);
endinterface

// ===== rtl/dac_serial_device.sv
`timescale 1ns/1ps
// Notes on behaviour
// - capture one bit per sclk fall after frame fall
// - act on word after sixteenth bit
// - host may hold or release frame after word
// - host keeps frame high 80 ns between words
// - early frame rise discards word, no change
// - sclk idle level free, sample falls only
// - staging and output register per channel
// - stage both channels without touching outputs
// - transparent load writes output directly
// - level code is unsigned straight binary
// - host sends trailing bits zero on loads
// - power command: select and termination decode
// - channels power down alone or together
// - power down keeps registers, wake restores
// - host waits 8 us after wake
// - power commands accepted at any time
// - reset clears registers, 100k power down
// - ignore link after sixteen bits until frame fall
// - word: code 15:12, level 11:2, trailing 1:0
// - single channel load, stage, transfer codes
// - dual channel load, stage, transfer codes
// - select 100 powers both channels
module dac_serial_device (
  input wire logic aclk,
  input wire logic aresetn,
  dac_serial_if.device link,
  output logic [dac_link_pkg::LEVEL_W-1:0] channel_a_output,
  output logic [dac_link_pkg::LEVEL_W-1:0] channel_b_output,
  output logic [dac_link_pkg::LEVEL_W-1:0] channel_a_staged,
  output logic [dac_link_pkg::LEVEL_W-1:0] channel_b_staged,
  output dac_link_pkg::power_t channel_a_power,
  output dac_link_pkg::power_t channel_b_power,
  output logic word_done
);
  // two-stage synchronisers for the link wires
  logic frame_s1_reg;
  logic frame_s2_reg;
  logic sclk_s1_reg;
  logic sclk_s2_reg;
  logic sdata_s1_reg;
  logic sdata_s2_reg;
  // delayed copies for edge detection
  logic frame_d_reg;
  logic sclk_d_reg;
  // receiver state
  dac_link_pkg::dev_state_t state_reg;
  logic [4:0] bit_cnt_reg;
  logic [dac_link_pkg::WORD_W-2:0] shift_reg;
  // decoded edges and the completed word
  logic frame_fall;
  logic sclk_fall;
  logic exec;
  logic [dac_link_pkg::WORD_W-1:0] word;
  logic [3:0] code;
  logic [dac_link_pkg::LEVEL_W-1:0] level_code;
  logic [2:0] power_select;
  logic [1:0] trailing_select_bits;
  // per-channel registers, index 0 is channel a
  logic [dac_link_pkg::LEVEL_W-1:0] staged_reg [2];
  logic [dac_link_pkg::LEVEL_W-1:0] out_reg [2];
  dac_link_pkg::power_t power_reg [2];

  // synchronise all three wires; the first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_s1_reg <= 1'b1;
      frame_s2_reg <= 1'b1;
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sdata_s1_reg <= 1'b0;
      sdata_s2_reg <= 1'b0;
    end else begin
      frame_s1_reg <= link.frame_n;
      frame_s2_reg <= frame_s1_reg;
      sclk_s1_reg <= link.sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sdata_s1_reg <= link.sdata;
      sdata_s2_reg <= sdata_s1_reg;
    end
  end

  // one-cycle history for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else begin
      frame_d_reg <= frame_s2_reg;
      sclk_d_reg <= sclk_s2_reg;
    end
  end

  // edges; only the falling sclk edge matters, so idle level is free
  assign frame_fall = frame_d_reg && !frame_s2_reg;
  assign sclk_fall = sclk_d_reg && !sclk_s2_reg;

  // sixteenth bit arriving while the frame is still low
  assign exec = (state_reg == dac_link_pkg::DEV_SHIFT) && !frame_s2_reg && sclk_fall
                && (bit_cnt_reg == dac_link_pkg::LAST_BIT);
  // new bit enters at the lsb, earlier bits move toward the msb
  assign word = {shift_reg, sdata_s2_reg};

  // field split of the completed word
  assign code = word[dac_link_pkg::CODE_MSB:dac_link_pkg::CODE_LSB];
  assign level_code = word[dac_link_pkg::LEVEL_MSB:dac_link_pkg::LEVEL_LSB];
  assign power_select = word[dac_link_pkg::SEL_MSB:dac_link_pkg::SEL_LSB];
  assign trailing_select_bits = word[dac_link_pkg::TRAIL_MSB:dac_link_pkg::TRAIL_LSB];

  // receiver sequence: wait for frame fall, shift sixteen bits, then go deaf
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= dac_link_pkg::DEV_IDLE;
    end else if (frame_fall) begin
      // a new frame always restarts reception
      state_reg <= dac_link_pkg::DEV_SHIFT;
    end else begin
      unique case (state_reg)
        dac_link_pkg::DEV_IDLE: begin
          state_reg <= dac_link_pkg::DEV_IDLE;
        end
        dac_link_pkg::DEV_SHIFT: begin
          if (frame_s2_reg) begin
            // frame released before the word completed: drop it
            state_reg <= dac_link_pkg::DEV_IDLE;
          end else if (exec) begin
            // sclk and data are ignored until the next frame fall
            state_reg <= dac_link_pkg::DEV_DONE;
          end
        end
        dac_link_pkg::DEV_DONE: begin
          // frame may stay low or rise here; the word is already used
          state_reg <= dac_link_pkg::DEV_DONE;
        end
        default: begin
          state_reg <= dac_link_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // bit counter and shift register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= '0;
    end else if (frame_fall) begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= '0;
    end else if (state_reg == dac_link_pkg::DEV_SHIFT && !frame_s2_reg && sclk_fall) begin
      // one bit per falling sclk edge
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      shift_reg <= word[dac_link_pkg::WORD_W-2:0];
    end
  end

  // one register set per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic picked;
    logic power_hit;
    // single-channel codes pick a channel by the code lsb
    assign picked = (code[0] == 1'(ch));
    // power command channel decode, both on select 100
    assign power_hit = (power_select == dac_link_pkg::SEL_AB) ||
                       (power_select == (ch == 0 ? dac_link_pkg::SEL_A : dac_link_pkg::SEL_B));

    // staging and output registers; outputs move only on output writes
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        staged_reg[ch] <= dac_link_pkg::LEVEL_RESET;
        out_reg[ch] <= dac_link_pkg::LEVEL_RESET;
      end else if (exec) begin
        unique case (code)
          dac_link_pkg::CODE_LOAD_A, dac_link_pkg::CODE_LOAD_B: begin
            // transparent: staging and output together
            if (picked) begin
              staged_reg[ch] <= level_code;
              out_reg[ch] <= level_code;
            end
          end
          dac_link_pkg::CODE_STAGE_A, dac_link_pkg::CODE_STAGE_B: begin
            if (picked) begin
              staged_reg[ch] <= level_code;
            end
          end
          dac_link_pkg::CODE_XFER_A, dac_link_pkg::CODE_XFER_B: begin
            if (picked) begin
              out_reg[ch] <= staged_reg[ch];
            end
          end
          dac_link_pkg::CODE_LOAD_AB: begin
            staged_reg[ch] <= level_code;
            out_reg[ch] <= level_code;
          end
          dac_link_pkg::CODE_STAGE_AB: begin
            // both staged, outputs untouched for a later joint update
            staged_reg[ch] <= level_code;
          end
          dac_link_pkg::CODE_XFER_AB: begin
            out_reg[ch] <= staged_reg[ch];
          end
          default: begin
            // power commands and undefined codes leave levels alone
          end
        endcase
      end
    end

    // power state; levels are kept so wake restores the old output
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        power_reg[ch] <= dac_link_pkg::POWER_RESET;
      end else if (exec && code == dac_link_pkg::CODE_POWER && power_hit) begin
        // no wait needed, taken whenever it arrives
        power_reg[ch] <= dac_link_pkg::power_t'(trailing_select_bits);
      end
    end
  end

  // completion pulse, one cycle after the word is acted on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_done <= 1'b0;
    end else begin
      word_done <= exec;
    end
  end

  assign channel_a_output = out_reg[0];
  assign channel_b_output = out_reg[1];
  assign channel_a_staged = staged_reg[0];
  assign channel_b_staged = staged_reg[1];
  assign channel_a_power = power_reg[0];
  assign channel_b_power = power_reg[1];
endmodule

// ===== rtl/dac_serial_host.sv
`timescale 1ns/1ps
// serial master driven by software over an axi4-lite slave port
module dac_serial_host #(
  parameter int SCLK_HALF = dac_link_pkg::SCLK_HALF_CYCLES,
  parameter int WAKE_WAIT = dac_link_pkg::WAKE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  dac_serial_if.host link,
  input wire logic awvalid,
  output logic awready,
  input wire logic [dac_link_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [dac_link_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  // write channel holding
  logic aw_held_reg;
  logic w_held_reg;
  logic [dac_link_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic cmd_ok;
  // command queue of one word
  logic pend_reg;
  logic [15:0] pend_word_reg;
  logic [15:0] tx_word_reg;
  // link sequencer
  dac_link_pkg::host_state_t state_reg;
  logic [7:0] half_cnt_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] gap_cnt_reg;
  logic [11:0] wake_cnt_reg;
  logic frame_n_reg;
  logic sclk_reg;
  logic sdata_reg;
  logic start;
  logic half_done;
  logic pend_hits_output;

  // write address and data are taken independently
  assign awready = !aw_held_reg && !bvalid;
  assign wready = !w_held_reg && !bvalid;
  assign arready = !rvalid;
  assign do_write = aw_held_reg && w_held_reg && !bvalid;
  assign cmd_ok = (awaddr_reg == dac_link_pkg::OFS_COMMAND) && !pend_reg
                  && (wstrb_reg[1:0] == 2'h3);

  // capture address and data, then answer once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid <= 1'b0;
      bresp <= dac_link_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid <= 1'b1;
        // status writes are ignored; busy or partial command writes fail
        bresp <= (cmd_ok || awaddr_reg == dac_link_pkg::OFS_STATUS) ?
                 dac_link_pkg::RESP_OKAY : dac_link_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= dac_link_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= dac_link_pkg::RESP_OKAY;
      if (araddr == dac_link_pkg::OFS_COMMAND) begin
        rdata <= {16'h0000, tx_word_reg};
      end else if (araddr == dac_link_pkg::OFS_STATUS) begin
        rdata <= {29'h0, wake_cnt_reg != 12'h000, !frame_n_reg, pend_reg};
      end else begin
        rdata <= '0;
        rresp <= dac_link_pkg::RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // pending command; trailing bits forced low except on power commands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg <= 1'b0;
      pend_word_reg <= '0;
    end else if (do_write && cmd_ok) begin
      pend_reg <= 1'b1;
      pend_word_reg <= (wdata_reg[15:12] == dac_link_pkg::CODE_POWER) ?
                       wdata_reg[15:0] : {wdata_reg[15:2], 2'h0};
    end else if (start) begin
      pend_reg <= 1'b0;
    end
  end

  // commands that write an output register must wait out a wake-up
  always_comb begin
    unique case (pend_word_reg[15:12])
      dac_link_pkg::CODE_LOAD_A, dac_link_pkg::CODE_LOAD_B,
      dac_link_pkg::CODE_XFER_A, dac_link_pkg::CODE_XFER_B,
      dac_link_pkg::CODE_LOAD_AB, dac_link_pkg::CODE_XFER_AB: pend_hits_output = 1'b1;
      default: pend_hits_output = 1'b0;
    endcase
  end

  // start when idle, the frame gap has passed and no wake wait blocks it
  assign start = (state_reg == dac_link_pkg::HOST_IDLE) && pend_reg
                 && (gap_cnt_reg == 8'h00)
                 && !(pend_hits_output && wake_cnt_reg != 12'h000);
  assign half_done = (half_cnt_reg == 8'(SCLK_HALF - 1));

  // frame, clock and data sequencer; sclk rests low, data moves on rises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= dac_link_pkg::HOST_IDLE;
      frame_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      sdata_reg <= 1'b0;
      half_cnt_reg <= 8'h00;
      bit_cnt_reg <= 5'h00;
      tx_word_reg <= '0;
    end else if (start) begin
      state_reg <= dac_link_pkg::HOST_SHIFT;
      frame_n_reg <= 1'b0;
      tx_word_reg <= pend_word_reg;
      half_cnt_reg <= 8'h00;
      bit_cnt_reg <= 5'h00;
    end else if (state_reg == dac_link_pkg::HOST_SHIFT) begin
      half_cnt_reg <= half_done ? 8'h00 : half_cnt_reg + 8'h01;
      if (half_done && sclk_reg) begin
        sclk_reg <= 1'b0;
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end else if (half_done && bit_cnt_reg == dac_link_pkg::BITS_PER_WORD) begin
        // release the frame after the sixteenth fall
        frame_n_reg <= 1'b1;
        state_reg <= dac_link_pkg::HOST_IDLE;
      end else if (half_done) begin
        sclk_reg <= 1'b1;
        // msb first, stable across the following fall
        sdata_reg <= tx_word_reg[4'(15 - bit_cnt_reg)];
      end
    end
  end

  // frame-high gap counter, reloaded as the frame ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_cnt_reg <= 8'h00;
    end else if (state_reg == dac_link_pkg::HOST_SHIFT && !frame_n_reg && half_done
                 && !sclk_reg && bit_cnt_reg == dac_link_pkg::BITS_PER_WORD) begin
      gap_cnt_reg <= 8'(dac_link_pkg::CS_GAP_CYCLES);
    end else if (gap_cnt_reg != 8'h00) begin
      gap_cnt_reg <= gap_cnt_reg - 8'h01;
    end
  end

  // wake-up recovery counter, started when a wake command goes out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_cnt_reg <= 12'h000;
    end else if (start && pend_word_reg[15:12] == dac_link_pkg::CODE_POWER
                 && pend_word_reg[1:0] == 2'h0) begin
      wake_cnt_reg <= 12'(WAKE_WAIT + 16 * 2 * SCLK_HALF + SCLK_HALF);
    end else if (wake_cnt_reg != 12'h000) begin
      wake_cnt_reg <= wake_cnt_reg - 12'h001;
    end
  end

  assign link.frame_n = frame_n_reg;
  assign link.sclk = sclk_reg;
  assign link.sdata = sdata_reg;
endmodule

// ===== tb/dac_serial_props.sv
`timescale 1ns/1ps
// watches the command link and the device's reaction to each word
module dac_serial_props #(
  parameter int SCLK_HALF = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic word_done,
  input wire logic [dac_link_pkg::LEVEL_W-1:0] channel_a_output,
  input wire logic [dac_link_pkg::LEVEL_W-1:0] channel_b_output
);
  logic sclk_q; // sclk one cycle back
  logic [5:0] hi_cnt; // cycles of the current sclk high phase
  logic [4:0] gap_cnt; // cycles frame has been high, saturates at 16
  logic [4:0] fall_cnt; // sclk falls in the current frame
  logic [15:0] word_q; // bits seen on the wire this frame
  wire sclk_fall = sclk_q && !sclk;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // sclk history for fall detection
  always_ff @(posedge aclk) begin
    sclk_q <= aresetn ? sclk : 1'b0;
  end
  // high-phase length
  always_ff @(posedge aclk) begin
    if (!aresetn || !sclk) hi_cnt <= 6'h00;
    else if (hi_cnt != 6'h3f) hi_cnt <= hi_cnt + 6'h01;
  end
  // frame-high time; starts full so the first frame after reset is free
  always_ff @(posedge aclk) begin
    if (!aresetn) gap_cnt <= 5'h10;
    else if (!frame_n) gap_cnt <= 5'h00;
    else if (gap_cnt != 5'h10) gap_cnt <= gap_cnt + 5'h01;
  end
  // bit count of the current frame
  always_ff @(posedge aclk) begin
    if (!aresetn || frame_n) fall_cnt <= 5'h00;
    else if (sclk_fall && fall_cnt != 5'h1f) fall_cnt <= fall_cnt + 5'h01;
  end
  // word as the device should see it, msb first
  always_ff @(posedge aclk) begin
    if (sclk_fall && !frame_n) word_q <= {word_q[14:0], sdata};
  end
  a_bit_setup: assert property ($rose(sclk) |=> $stable(sdata) [*8])
    else $error("sdata moved while sclk high");
  a_half_period: assert property ($fell(sclk) && !frame_n |-> hi_cnt == SCLK_HALF)
    else $error("sclk high phase has wrong length");
  a_sclk_rest: assert property (frame_n |-> !sclk)
    else $error("sclk high outside a frame");
  a_frame_gap: assert property ($fell(frame_n) |-> gap_cnt >= 5'h0f)
    else $error("frame high gap too short");
  a_whole_word: assert property ($rose(frame_n) |-> fall_cnt == 5'h10)
    else $error("frame did not carry sixteen bits");
  a_trail_zero: assert property ($rose(frame_n) && word_q[15:12] != 4'hf |->
    word_q[1:0] == 2'h0)
    else $error("trailing bits not zero on a load");
  a_act_on_word: assert property (sclk_fall && !frame_n && fall_cnt == 5'h0f |->
    ##[1:8] word_done)
    else $error("word not acted on after sixteenth bit");
  a_done_in_frame: assert property (word_done |-> fall_cnt == 5'h10)
    else $error("word acted on without sixteen bits");
  a_output_cause: assert property ($changed(channel_a_output) || $changed(channel_b_output)
    |-> word_done)
    else $error("output changed without a word");
  c_word: cover property (word_done);
  c_power_word: cover property ($rose(frame_n) && word_q[15:12] == 4'hf);
  c_both_out: cover property ($changed(channel_a_output) && $changed(channel_b_output));
endmodule

// ===== tb/test_dual_dac_serial_control.sv
`timescale 1ns/1ps
// drives the host over axi4-lite and checks both device ends
module test_dual_dac_serial_control;
  localparam int WAKE_SIM = 20; // short wake wait keeps the run brief
  localparam logic [43:0] RST = {40'h0, 2'h3, 2'h3}; // cleared, 100k power-down
  // command, then expected a, b, staged a, staged b, power a, power b
  localparam logic [59:0] ROWS [20] = '{
    {16'hf000, 10'h000, 10'h000, 10'h000, 10'h000, 2'h0, 2'h3},
    {16'hf004, 10'h000, 10'h000, 10'h000, 10'h000, 2'h0, 2'h0},
    {16'h0ffc, 10'h3ff, 10'h000, 10'h3ff, 10'h000, 2'h0, 2'h0},
    {16'h1554, 10'h3ff, 10'h155, 10'h3ff, 10'h155, 2'h0, 2'h0},
    {16'h4aa8, 10'h3ff, 10'h155, 10'h2aa, 10'h155, 2'h0, 2'h0},
    {16'h5004, 10'h3ff, 10'h155, 10'h2aa, 10'h001, 2'h0, 2'h0},
    {16'h8000, 10'h2aa, 10'h155, 10'h2aa, 10'h001, 2'h0, 2'h0},
    {16'h9000, 10'h2aa, 10'h001, 10'h2aa, 10'h001, 2'h0, 2'h0},
    {16'hd3c0, 10'h2aa, 10'h001, 10'h0f0, 10'h0f0, 2'h0, 2'h0},
    {16'he000, 10'h0f0, 10'h0f0, 10'h0f0, 10'h0f0, 2'h0, 2'h0},
    {16'hc800, 10'h200, 10'h200, 10'h200, 10'h200, 2'h0, 2'h0},
    {16'h2ffc, 10'h200, 10'h200, 10'h200, 10'h200, 2'h0, 2'h0},
    {16'hbffc, 10'h200, 10'h200, 10'h200, 10'h200, 2'h0, 2'h0},
    {16'hf008, 10'h200, 10'h200, 10'h200, 10'h200, 2'h0, 2'h0},
    {16'hf001, 10'h200, 10'h200, 10'h200, 10'h200, 2'h1, 2'h0},
    {16'hf006, 10'h200, 10'h200, 10'h200, 10'h200, 2'h1, 2'h2},
    {16'hf013, 10'h200, 10'h200, 10'h200, 10'h200, 2'h3, 2'h3},
    {16'hf010, 10'h200, 10'h200, 10'h200, 10'h200, 2'h0, 2'h0},
    {16'hf001, 10'h200, 10'h200, 10'h200, 10'h200, 2'h1, 2'h0},
    {16'h1004, 10'h200, 10'h001, 10'h200, 10'h001, 2'h1, 2'h0}};
  logic aclk, aresetn, word_done;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [dac_link_pkg::LEVEL_W-1:0] ca, cb, sa, sb, ca2, cb2, sa2, sb2;
  dac_link_pkg::power_t pa, pb, pa2, pb2;
  int failures, checks, cyc;
  wire [43:0] st = {ca, cb, sa, sb, pa, pb}; // first device state
  wire [43:0] st2 = {ca2, cb2, sa2, sb2, pa2, pb2}; // second device state
  dac_serial_if link();
  dac_serial_if link2(); // driven by the bench to break framing on purpose
  dac_serial_host #(.WAKE_WAIT(WAKE_SIM)) i_dac_serial_host (.aclk(aclk), .aresetn(aresetn),
    .link(link), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp));
  dac_serial_device i_dac_serial_device (.aclk(aclk), .aresetn(aresetn), .link(link),
    .channel_a_output(ca), .channel_b_output(cb), .channel_a_staged(sa),
    .channel_b_staged(sb), .channel_a_power(pa), .channel_b_power(pb), .word_done(word_done));
  dac_serial_device i_dac_serial_device_2 (.aclk(aclk), .aresetn(aresetn), .link(link2),
    .channel_a_output(ca2), .channel_b_output(cb2), .channel_a_staged(sa2),
    .channel_b_staged(sb2), .channel_a_power(pa2), .channel_b_power(pb2), .word_done());
  dac_serial_props #(.SCLK_HALF(dac_link_pkg::SCLK_HALF_CYCLES)) i_dac_serial_props (
    .aclk(aclk), .aresetn(aresetn), .frame_n(link.frame_n), .sclk(link.sclk),
    .sdata(link.sdata), .word_done(word_done), .channel_a_output(ca), .channel_b_output(cb));
  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      summarize();
    end
  end
  task automatic check_regs(input logic [43:0] got, input logic [43:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t state got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_bus(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t bus got %h exp %h", $time, got, exp);
    end
  endtask
  // one axi4-lite write; address and data offered together
  task automatic axi_write(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  // one axi4-lite read
  task automatic axi_read(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // queue a command and wait until the device has acted on it
  task automatic send(input logic [15:0] cmd);
    int n;
    axi_write(dac_link_pkg::OFS_COMMAND, {16'h0000, cmd}, 4'hf);
    check_bus({30'h0, r}, {30'h0, dac_link_pkg::RESP_OKAY});
    n = 0;
    while (word_done !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    check_bus({31'h0, word_done}, 32'h1);
    @(posedge aclk);
  endtask
  // bench-made frame on the second link; sclk rests high, n bits msb first
  task automatic raw(input logic [19:0] w, input int n);
    @(posedge aclk) link2.frame_n <= 1'b0;
    repeat (4) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      link2.sdata <= w[19-i];
      repeat (6) @(posedge aclk);
      link2.sclk <= 1'b0;
      repeat (12) @(posedge aclk);
      link2.sclk <= 1'b1;
      repeat (7) @(posedge aclk);
    end
    link2.frame_n <= 1'b1;
    link2.sdata <= ~w[20-n];
    repeat (20) @(posedge aclk);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    {link2.frame_n, link2.sclk, link2.sdata} = 3'h6;
    {failures, checks, cyc} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_regs(st, RST);
    $display("test reset done");
    for (int i = 0; i < 20; i++) begin
      send(ROWS[i][59:44]);
      check_regs(st, ROWS[i][43:0]);
    end
    $display("test command table done");
    axi_read(dac_link_pkg::OFS_COMMAND);
    check_bus(d, {16'h0000, ROWS[19][59:44]});
    axi_write(dac_link_pkg::OFS_STATUS, 32'h0000ffff, 4'hf);
    check_bus({30'h0, r}, {30'h0, dac_link_pkg::RESP_OKAY});
    axi_write(4'h8, 32'h0000ffff, 4'hf);
    check_bus({30'h0, r}, {30'h0, dac_link_pkg::RESP_SLVERR});
    axi_write(dac_link_pkg::OFS_COMMAND, 32'h00000ffc, 4'h1);
    check_bus({30'h0, r}, {30'h0, dac_link_pkg::RESP_SLVERR});
    repeat (60) @(posedge aclk);
    axi_read(dac_link_pkg::OFS_STATUS);
    check_bus(d, 32'h0);
    axi_read(4'h8);
    check_bus({d[29:0], r}, {30'h0, dac_link_pkg::RESP_SLVERR});
    check_regs(st, ROWS[19][43:0]);
    $display("test register access done");
    raw({16'h0ffc, 4'h0}, 10);
    check_regs(st2, RST);
    raw({16'h1554, 4'hf}, 20);
    check_regs(st2, {10'h0, 10'h155, 10'h0, 10'h155, 2'h3, 2'h3});
    $display("test faulty framing done");
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    check_regs(st, RST);
    check_regs(st2, RST);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check_regs(st, RST);
    $display("test second reset done");
    summarize();
  end
endmodule
